// *** verif/urh_regs_sva.sv ***
// checker for the root hub register bank, bound to urh_regs
// assumes one clock domain and the package command codes
`timescale 1ns/100ps

module urh_regs_sva (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        clk_en,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_code,
    input wire logic [31:0] wr_data,
    input wire logic [31:0] rd_data,
    input wire logic        rd_valid,
    input wire logic [1:0]  hc_state,
    input wire logic        port_count_strap,
    input wire logic [1:0]  overcurrent_pin,
    input wire logic        global_power_set,
    input wire logic        global_power_clr,
    input wire logic [1:0]  port_power_set,
    input wire logic [1:0]  port_power_clr,
    input wire logic [1:0]  port_power,
    input wire logic [1:0]  overcurrent_status,
    input wire logic [7:0]  power_good_wait_units
);
    import urh_pkg::*;

    logic [2:0] mir;
    logic       rd_cmd;
    logic       wr_first;
    logic       coll;
    logic       rd_first;

    // ==========================================================
    // helpers: mirror of no-oc, oc-mode and always-on bits
    assign rd_cmd = clk_en && cmd_valid && cmd_code >= 8'h12
                    && cmd_code <= 8'h16;
    assign wr_first = clk_en && cmd_valid && cmd_code == CMD_DESC_FIRST_WR;
    assign coll = !mir[2] && !mir[1];

    // mirror follows taken writes only, so frozen cycles leave it alone
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mir <= 3'h2;
            rd_first <= 1'b0;
        end else begin
            rd_first <= clk_en && cmd_valid && cmd_code == CMD_DESC_FIRST_RD;
            if (wr_first) begin
                mir <= {wr_data[12], wr_data[11], wr_data[9]};
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // ==========================================================
    // assertions
    a_read_answer: assert property (
        rd_cmd |=> rd_valid) else $error("read got no answer");
    a_no_spurious: assert property (
        clk_en && !rd_cmd |=> !rd_valid) else $error("stray read pulse");
    a_rd_holds: assert property (
        clk_en && !rd_cmd |=> $stable(rd_data))
        else $error("read word moved");
    a_fixed_bits: assert property (
        rd_valid && rd_first |-> rd_data[23:13] == 11'h000
        && !rd_data[10] && rd_data[7:2] == 6'h00)
        else $error("fixed descriptor bits not zero");
    a_port_count: assert property (
        rd_valid && rd_first |-> rd_data[1:0] inside {2'h1, 2'h2})
        else $error("bad port count");
    a_wait_copy: assert property (
        wr_first |=> power_good_wait_units == $past(wr_data[31:24]))
        else $error("wait units not updated");
    a_always_on: assert property (
        mir[0] && $past(mir[0]) && $past(mir[0], 2) |-> port_power == 2'h3)
        else $error("ports not always powered");
    a_no_oc: assert property (
        mir[2] && $past(mir[2]) && $past(mir[2], 2)
        |-> overcurrent_status == 2'h0) else $error("oc reported");
    a_oc_collective: assert property (
        coll && $past(coll) && $past(coll, 2) && overcurrent_status[1]
        |-> overcurrent_status[0]) else $error("oc not collective");
endmodule

bind urh_regs urh_regs_sva urh_regs_sva_inst (.core_clk, .reset, .clk_en,
    .cmd_valid, .cmd_code, .wr_data, .rd_data, .rd_valid, .hc_state,
    .port_count_strap, .overcurrent_pin, .global_power_set,
    .global_power_clr, .port_power_set, .port_power_clr, .port_power,
    .overcurrent_status, .power_good_wait_units);

// *** verif/urh_regs_tb.sv ***
// random bench for urh_regs against a behavioural register model
// assumes the checker is bound in; clk_en drops once in each phase
`timescale 1ns/100ps

module urh_regs_tb;
    import urh_pkg::*;

    logic        core_clk;
    logic        reset;
    logic        clk_en;
    logic        cmd_valid;
    logic [7:0]  cmd_code;
    logic [31:0] wr_data;
    logic [31:0] rd_data;
    logic        rd_valid;
    logic [1:0]  hc_state;
    logic        port_count_strap;
    logic [1:0]  overcurrent_pin;
    logic        global_power_set;
    logic        global_power_clr;
    logic [1:0]  port_power_set;
    logic [1:0]  port_power_clr;
    logic [1:0]  port_power;
    logic [1:0]  overcurrent_status;
    logic [7:0]  power_good_wait_units;
    int          error_cnt;
    int          total_checks;
    int          seed;
    int          m_k;
    int          m_still;
    bit [31:0]   r;
    bit [31:0]   m_reg [0:4];
    bit [31:0]   m_rd;
    bit [1:0]    m_pp;
    bit [1:0]    m_pins;
    bit [1:0]    m_cnt;
    bit          m_rv;
    bit          m_z;
    bit [7:0]    codes [0:11] = '{8'h12, 8'h92, 8'h13, 8'h93, 8'h14, 8'h94,
                                 8'h15, 8'h95, 8'h16, 8'h96, 8'h17, 8'h97};

    urh_regs urh_regs_inst (.core_clk, .reset, .clk_en, .cmd_valid,
        .cmd_code, .wr_data, .rd_data, .rd_valid, .hc_state,
        .port_count_strap, .overcurrent_pin, .global_power_set,
        .global_power_clr, .port_power_set, .port_power_clr, .port_power,
        .overcurrent_status, .power_good_wait_units);

    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    // ==========================================================
    // compare and closing tasks
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: word %h model %h", $time, got, exp);
        end
    endtask

    task automatic chk_small(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: field %h model %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // reported overcurrent; port 2 absent when only one port is strapped
    function automatic bit [1:0] m_oc();
        if (m_reg[0][12]) return 2'h0;
        if (m_reg[0][11]) return m_pins & {m_cnt[1], 1'b1};
        return {2{|m_pins}} & {m_cnt[1], 1'b1};
    endfunction

    // model: power acts on the descriptors as they stood before this edge
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            m_reg = '{{24'hFF0009, 6'h00, m_cnt}, 0, 0, 0, 0};
            m_pp = 2'h0;
            m_rv = 1'b0;
            m_still = 0;
        end else if (clk_en) begin
            m_rv = 1'b0;
            if (m_reg[0][9]) m_pp = 2'h3;
            else if (!m_reg[0][8]) begin
                if (global_power_set || port_power_set != 2'h0) m_pp = 2'h3;
                else if (global_power_clr || port_power_clr != 2'h0)
                    m_pp = 2'h0;
            end else begin
                for (int n = 0; n < 2; n++) begin
                    if (m_reg[1][17+n] ? port_power_set[n] : global_power_set)
                        m_pp[n] = 1'b1;
                    else if (m_reg[1][17+n] ? port_power_clr[n]
                             : global_power_clr) m_pp[n] = 1'b0;
                end
            end
            if (overcurrent_pin != m_pins) m_still = 0;
            else if (m_still < 8) m_still++;
            m_pins = overcurrent_pin;
            m_k = cmd_code[6:0] - 7'h12;
            m_z = m_k == 4 && m_cnt == 2'h1;
            if (cmd_valid && m_k >= 0 && m_k <= 4) begin
                if (!cmd_code[7]) begin
                    m_rv = 1'b1;
                    m_rd = m_z ? 32'h0 : m_reg[m_k];
                end else if (m_k < 2) begin
                    m_reg[m_k] = m_k == 1 ? wr_data & 32'h0006_0006
                        : (m_reg[0] & ~32'hFF00_1B00)
                        | (wr_data & 32'hFF00_1B00);
                    m_still = 0;
                end else if (hc_state == OPERATIONAL_STATE && !m_z) begin
                    m_reg[m_k] = wr_data;
                end
            end
        end
    end

    // outputs are settled by the falling edge
    always @(negedge core_clk) begin
        if (!reset) begin
            chk_small({7'h00, rd_valid}, {7'h00, m_rv});
            if (m_rv) chk_word(rd_data, m_rd);
            chk_small({6'h00, port_power}, {6'h00, m_pp});
            chk_small(power_good_wait_units, m_reg[0][31:24]);
            if (m_still > 4)
                chk_small({6'h00, overcurrent_status}, {6'h00, m_oc()});
        end
    end

    task automatic cmd(input bit [7:0] c, input bit [31:0] d);
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        wr_data <= d;
    endtask

    // ==========================================================
    // main sequence: strap high, then a second reset with strap low
    initial begin
        seed = 32'h227d9b4c;
        error_cnt = 0;
        total_checks = 0;
        {clk_en, reset, port_count_strap, m_cnt} = {3'b111, 2'h2};
        {cmd_valid, cmd_code, wr_data, hc_state} = 43'h0;
        {overcurrent_pin, global_power_set, global_power_clr} = 4'h0;
        {port_power_set, port_power_clr} = 4'h0;
        for (int ph = 0; ph < 2; ph++) begin
            repeat (8) @(posedge core_clk);
            reset <= 1'b0;
            repeat (6) @(posedge core_clk);
            cmd(CMD_DESC_FIRST_RD, 32'h0);
            cmd(CMD_DESC_SECOND_RD, 32'h0);
            // freeze over a read answer: the answer must hold and the power pulse, dropped as the freeze ends, must not act
            @(posedge core_clk);
            clk_en <= 1'b0;
            global_power_set <= 1'b1;
            repeat (3) @(posedge core_clk);
            clk_en <= 1'b1;
            global_power_set <= 1'b0;
            cmd(CMD_DESC_FIRST_WR, 32'hFF00_0100);
            cmd(CMD_DESC_FIRST_WR, 32'hFF00_0900);
            for (int i = 0; i < 500; i++) begin
                @(posedge core_clk);
                r = $random(seed);
                cmd_valid <= r[0] | r[1];
                cmd_code <= codes[r[7:4] % 4'd12];
                wr_data <= $random(seed) & 32'hFFFF_FDFF;
                hc_state <= r[9:8];
                global_power_set <= r[12:10] == 3'h0;
                global_power_clr <= r[15:13] == 3'h0;
                port_power_set <= r[17:16] & {2{r[18]}};
                port_power_clr <= r[20:19] & {2{r[21] & r[22]}};
                if (i % 16 == 0) overcurrent_pin <= r[24:23];
            end
            cmd(CMD_DESC_FIRST_WR, 32'h0000_1200);
            {global_power_set, global_power_clr} <= 2'h0;
            {port_power_set, port_power_clr} <= 4'h0;
            @(posedge core_clk);
            cmd_valid <= 1'b0;
            repeat (8) @(posedge core_clk);
            reset <= 1'b1;
            port_count_strap <= 1'b0;
            m_cnt = 2'h1;
        end
        end_of_test();
    end

    // watchdog: the run needs about 1100 cycles
    initial begin
        #50000;
        error_cnt++;
        end_of_test();
    end
endmodule

// *** verilog/urh_pkg.sv ***
// root hub register constants: command codes, field positions, resets
// assumes one controller clock; no bus beyond the command-code port
package urh_pkg;

    // ==========================================================
    // command codes
    localparam logic [7:0] CMD_DESC_FIRST_RD  = 8'h12;
    localparam logic [7:0] CMD_DESC_FIRST_WR  = 8'h92;
    localparam logic [7:0] CMD_DESC_SECOND_RD = 8'h13;
    localparam logic [7:0] CMD_DESC_SECOND_WR = 8'h93;
    localparam logic [7:0] CMD_HUB_STATUS_RD  = 8'h14;
    localparam logic [7:0] CMD_HUB_STATUS_WR  = 8'h94;
    localparam logic [7:0] CMD_PORT1_RD       = 8'h15;
    localparam logic [7:0] CMD_PORT1_WR       = 8'h95;
    localparam logic [7:0] CMD_PORT2_RD       = 8'h16;
    localparam logic [7:0] CMD_PORT2_WR       = 8'h96;

    // ==========================================================
    // controller state in which status registers accept writes
    localparam logic [1:0] OPERATIONAL_STATE  = 2'h2;

    // ==========================================================
    // first descriptor field positions
    localparam int POWER_GOOD_WAIT_LSB        = 24;
    localparam int OVERCURRENT_UNSUPP_BIT     = 12;
    localparam int OVERCURRENT_PER_PORT_BIT   = 11;
    localparam int COMPOUND_DEVICE_BIT        = 10;
    localparam int ALWAYS_POWERED_BIT         = 9;
    localparam int INDIVIDUAL_SWITCH_BIT      = 8;
    localparam int PORT_COUNT_LSB             = 0;

    // second descriptor field positions
    localparam int PORT_POWER_MASK_LSB        = 16;
    localparam int DEVICE_REMOVABLE_LSB       = 0;

    // ==========================================================
    // reset values
    localparam logic [7:0] POWER_GOOD_WAIT_RST      = 8'hFF;
    localparam logic       OVERCURRENT_UNSUPP_RST   = 1'b0;
    localparam logic       INDIVIDUAL_SWITCH_RST    = 1'b1;
    localparam logic       OVERCURRENT_PER_PORT_RST = INDIVIDUAL_SWITCH_RST;
    localparam logic       ALWAYS_POWERED_RST       = 1'b0;
    localparam logic [1:0] PORT_COUNT_TWO           = 2'h2;
    localparam logic [1:0] PORT_COUNT_ONE           = 2'h1;
    localparam logic [2:0] MASK_RST                 = 3'h0;
    localparam logic [31:0] WORD_RST                = 32'h0000_0000;

    // timing: power-good unit and edges before the strap is trusted
    localparam int POWER_GOOD_UNIT_MS         = 2;
    localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

endpackage

// *** verilog/urh_power.sv ***
// port power switch: ganged, individual and always-on modes
// assumes single-cycle command pulses from the register side
`timescale 1ns/100ps

module urh_power (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic clk_en,
    urh_pwr_if.sw     pwr
);
    typedef struct packed {
        logic [1:0] power;
    } urh_power_state_t;

    urh_power_state_t state;
    urh_power_state_t next_state;

    // ==========================================================
    // per-port decision; set wins over clear in the same cycle
    always_comb begin
        next_state = state;
        if (clk_en) begin
            for (int p = 0; p < 2; p++) begin
                if (pwr.always_powered) begin
                    next_state.power[p] = 1'b1;
                end else if (!pwr.individual_switch) begin
                    // ganged: any command moves every port
                    if (pwr.global_power_set || |pwr.port_power_set) begin
                        next_state.power[p] = 1'b1;
                    end else if (pwr.global_power_clr ||
                                 |pwr.port_power_clr) begin
                        next_state.power[p] = 1'b0;
                    end
                end else if (pwr.port_power_mask[p+1]) begin
                    if (pwr.port_power_set[p]) begin
                        next_state.power[p] = 1'b1;
                    end else if (pwr.port_power_clr[p]) begin
                        next_state.power[p] = 1'b0;
                    end
                end else begin
                    if (pwr.global_power_set) begin
                        next_state.power[p] = 1'b1;
                    end else if (pwr.global_power_clr) begin
                        next_state.power[p] = 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pwr.port_power = state.power;
endmodule

// *** verilog/urh_pwr_if.sv ***
// carrier between the register block and the port power switch
// assumes both ends run on the same controller clock
`timescale 1ns/100ps

interface urh_pwr_if;
    logic       always_powered;      // ports powered whenever hc is
    logic       individual_switch;   // per-port switching mode
    logic [2:0] port_power_mask;     // bit n masks port n, bit 0 spare
    logic       global_power_set;
    logic       global_power_clr;
    logic [1:0] port_power_set;
    logic [1:0] port_power_clr;
    logic [1:0] port_power;

    modport regs (
        output always_powered,
        output individual_switch,
        output port_power_mask,
        output global_power_set,
        output global_power_clr,
        output port_power_set,
        output port_power_clr,
        input  port_power
    );

    modport sw (
        input  always_powered,
        input  individual_switch,
        input  port_power_mask,
        input  global_power_set,
        input  global_power_clr,
        input  port_power_set,
        input  port_power_clr,
        output port_power
    );
endinterface

// *** verilog/urh_regs.sv ***
// root hub descriptor, hub status and port status register bank
// assumes command-code strobes on core_clk from the host interface,
// and pins (strap, overcurrent) arriving asynchronously
`timescale 1ns/100ps

module urh_regs (
    // clocking
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    // register port
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [31:0] wr_data,
    output      logic [31:0] rd_data,
    output      logic        rd_valid,
    // state and pins
    input  wire logic [1:0]  hc_state,
    input  wire logic        port_count_strap,
    input  wire logic [1:0]  overcurrent_pin,
    // power commands
    input  wire logic        global_power_set,
    input  wire logic        global_power_clr,
    input  wire logic [1:0]  port_power_set,
    input  wire logic [1:0]  port_power_clr,
    // results
    output      logic [1:0]  port_power,
    output      logic [1:0]  overcurrent_status,
    output      logic [7:0]  power_good_wait_units
);
    import urh_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0]  power_good_wait;
        logic        overcurrent_unsupported;
        logic        overcurrent_report_per_port;
        logic        ports_always_powered;
        logic        individual_power_switching;
        logic [1:0]  downstream_port_count;

        logic [1:0]  strap_wait;
        logic        strap_taken;

        logic [2:0]  port_power_mask;
        logic [2:0]  device_removable;

        logic [31:0] hub_status;
        logic [31:0] port_status_1;
        logic [31:0] port_status_2;

        logic [31:0] rd_data;
        logic        rd_valid;
        logic [1:0]  oc_status;
    } urh_regs_state_t;

    urh_regs_state_t state;
    urh_regs_state_t next_state;

    logic [0:0] strap_sync;
    logic [1:0] oc_sync;

    // ==========================================================
    // word images of the descriptors
    function automatic logic [31:0] first_word(urh_regs_state_t s);
        logic [31:0] w;

        w = WORD_RST;
        w[POWER_GOOD_WAIT_LSB +: 8]     = s.power_good_wait;
        w[OVERCURRENT_UNSUPP_BIT]       = s.overcurrent_unsupported;
        w[OVERCURRENT_PER_PORT_BIT]     = s.overcurrent_report_per_port;
        w[COMPOUND_DEVICE_BIT]          = 1'b0;
        w[ALWAYS_POWERED_BIT]           = s.ports_always_powered;
        w[INDIVIDUAL_SWITCH_BIT]        = s.individual_power_switching;
        w[PORT_COUNT_LSB +: 2]          = s.downstream_port_count;
        return w;
    endfunction

    function automatic logic [31:0] second_word(urh_regs_state_t s);
        logic [31:0] w;

        w = WORD_RST;
        w[PORT_POWER_MASK_LSB +: 3]  = {s.port_power_mask[2:1], 1'b0};
        w[DEVICE_REMOVABLE_LSB +: 3] = {s.device_removable[2:1], 1'b0};
        return w;
    endfunction

    // ==========================================================
    // pin synchronisers; strap sync idles low while held in reset
    urh_sync #(.WIDTH(1)) u_strap_sync (
        .core_clk  (core_clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .pin_in    (port_count_strap),
        .rst_level (1'b0),
        .level_out (strap_sync)
    );

    urh_sync #(.WIDTH(2)) u_oc_sync (
        .core_clk  (core_clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .pin_in    (overcurrent_pin),
        .rst_level (2'h0),
        .level_out (oc_sync)
    );

    // ==========================================================
    // port power switch
    // switch modes come from the registered descriptors
    urh_pwr_if pwr ();

    assign pwr.always_powered    = state.ports_always_powered;
    assign pwr.individual_switch = state.individual_power_switching;
    assign pwr.port_power_mask   = state.port_power_mask;
    assign pwr.global_power_set  = global_power_set;
    assign pwr.global_power_clr  = global_power_clr;
    assign pwr.port_power_set    = port_power_set;
    assign pwr.port_power_clr    = port_power_clr;

    urh_power u_power (
        .core_clk (core_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .pwr      (pwr.sw)
    );

    // ==========================================================
    // command decode, strap capture and overcurrent reporting
    always_comb begin
        logic operational;
        logic two_ports;

        operational = (hc_state == OPERATIONAL_STATE);
        two_ports   = (state.downstream_port_count == PORT_COUNT_TWO);
        next_state  = state;

        if (clk_en) begin
            // read answer is a one-cycle pulse unless a read lands
            next_state.rd_valid = 1'b0;

            // strap is trusted once the synchroniser has filled
            // captured once; later strap moves are not followed
            if (!state.strap_taken) begin
                if (state.strap_wait == STRAP_SETTLE_CYCLES) begin
                    next_state.strap_taken = 1'b1;
                    next_state.downstream_port_count =
                        strap_sync[0] ? PORT_COUNT_TWO : PORT_COUNT_ONE;
                end else begin
                    next_state.strap_wait = state.strap_wait + 2'h1;
                end
            end

            // overcurrent: none, collective or per port
            // pins pass two flops, so status trails them by three edges
            if (state.overcurrent_unsupported) begin
                next_state.oc_status = 2'h0;
            end else if (!state.overcurrent_report_per_port) begin
                next_state.oc_status = {2{|oc_sync}};
            end else begin
                next_state.oc_status = oc_sync;
            end

            if (!two_ports) begin
                next_state.oc_status[1] = 1'b0;
            end

            if (cmd_valid) begin
                // reads return the full double word; descriptor writes keep only their fields
                case (cmd_code)
                    CMD_DESC_FIRST_RD: begin
                        next_state.rd_data  = first_word(state);
                        next_state.rd_valid = 1'b1;
                    end

                    CMD_DESC_FIRST_WR: begin
                        next_state.power_good_wait =
                            wr_data[POWER_GOOD_WAIT_LSB +: 8];

                        next_state.overcurrent_unsupported =
                            wr_data[OVERCURRENT_UNSUPP_BIT];

                        next_state.overcurrent_report_per_port =
                            wr_data[OVERCURRENT_PER_PORT_BIT];

                        next_state.ports_always_powered =
                            wr_data[ALWAYS_POWERED_BIT];

                        next_state.individual_power_switching =
                            wr_data[INDIVIDUAL_SWITCH_BIT];
                    end

                    CMD_DESC_SECOND_RD: begin
                        next_state.rd_data  = second_word(state);
                        next_state.rd_valid = 1'b1;
                    end

                    CMD_DESC_SECOND_WR: begin
                        // bit 0 of both fields is spare and stays zero
                        next_state.port_power_mask = {
                            wr_data[PORT_POWER_MASK_LSB + 2],
                            wr_data[PORT_POWER_MASK_LSB + 1],
                            1'b0};

                        next_state.device_removable = {
                            wr_data[DEVICE_REMOVABLE_LSB + 2],
                            wr_data[DEVICE_REMOVABLE_LSB + 1],
                            1'b0};
                    end

                    CMD_HUB_STATUS_RD: begin
                        next_state.rd_data  = state.hub_status;
                        next_state.rd_valid = 1'b1;
                    end

                    CMD_HUB_STATUS_WR: begin
                        // status words are stored as opaque words
                        if (operational) begin
                            next_state.hub_status = wr_data;
                        end
                    end

                    CMD_PORT1_RD: begin
                        next_state.rd_data  = state.port_status_1;
                        next_state.rd_valid = 1'b1;
                    end

                    CMD_PORT1_WR: begin
                        if (operational) begin
                            next_state.port_status_1 = wr_data;
                        end
                    end

                    CMD_PORT2_RD: begin
                        // port 2 exists only when two are reported
                        next_state.rd_data  =
                            two_ports ? state.port_status_2 : WORD_RST;
                        next_state.rd_valid = 1'b1;
                    end

                    CMD_PORT2_WR: begin
                        // a one-port hub has no second status word
                        if (operational && two_ports) begin
                            next_state.port_status_2 = wr_data;
                        end
                    end

                    default: begin
                        // unknown codes are ignored, nothing answers
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // registers; overcurrent mode resets to the switching mode
    // reset loads constants only; the port count waits for the strap
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state                             <= '0;
            state.power_good_wait             <= POWER_GOOD_WAIT_RST;
            state.overcurrent_unsupported     <= OVERCURRENT_UNSUPP_RST;
            state.overcurrent_report_per_port <=
                OVERCURRENT_PER_PORT_RST;
            state.ports_always_powered        <= ALWAYS_POWERED_RST;
            state.individual_power_switching  <= INDIVIDUAL_SWITCH_RST;
            state.downstream_port_count       <= PORT_COUNT_TWO;
            state.port_power_mask             <= MASK_RST;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // outputs
    // every data output is a flip-flop, no logic after the state
    assign rd_data               = state.rd_data;
    assign rd_valid              = state.rd_valid;
    assign overcurrent_status    = state.oc_status;
    assign power_good_wait_units = state.power_good_wait;
    assign port_power            = pwr.port_power;
endmodule

// *** verilog/urh_sync.sv ***
// two-flop synchroniser for pin levels
// assumes pins are asynchronous to core_clk
`timescale 1ns/100ps

module urh_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] pin_in,
    input  wire logic [WIDTH-1:0] rst_level,
    output      logic [WIDTH-1:0] level_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } urh_sync_state_t;

    urh_sync_state_t state;
    urh_sync_state_t next_state;

    // ==========================================================
    // first stage feeds only the second stage
    always_comb begin
        next_state = state;
        if (clk_en) begin
            next_state.meta   = pin_in;
            next_state.stable = state.meta;
        end
    end

    // reset takes a constant only; rst_level must be tied off
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign level_out = state.stable ^ rst_level ^ rst_level;
endmodule
